// ==== fmb_map.svh ====
/*
  Constants for the flash mode and boot controller: array geometry, erase block
  bases, page size, boot area placement and serial rate measurement figures.
  Assumes it is included by the package and by the design modules.
*/
// Notes on behaviour
// - The array is programmed only in whole 128-byte units, one unit per program operation.
// - Block erasure acts on one block at a time, over the ten blocks of 32, 28, 16, 8 and 1 kbyte.
// - Plain user mode allows reads but refuses every program and erase request.
// - The operating mode comes from the mode pins and program enable pin seen at reset release.
// - Boot mode erases the entire array in one operation and offers no block erase.
// - User program mode erases and programs individually selected blocks.
// - Every erased byte reads back as all ones.
// - On boot entry the host sends the control program over the serial port into RAM.
// - Boot mode copies the erase routine into a reserved RAM boot area before erasing.
// - Boot mode measures the host serial rate and sets its own bit rate to match.
// - After transfer the RAM control program runs and writes the host image into the array.
// - A programming unit starts at an address whose low eight bits are 00 or 80 hex.
// - A read-only status bit is one while the program enable pin is low and zero when high.
`ifndef FMB_MAP_SVH
`define FMB_MAP_SVH

`define FMB_ADDR_W 17
`define FMB_ARRAY_LAST 17'h1ffff
`define FMB_ERASED_BYTE 8'hff
`define FMB_PAGE_BYTES 128
`define FMB_PAGE_IDX_W 7
`define FMB_PAGE_LAST 7'h7f
`define FMB_BLOCK_LAST 4'h9
`define FMB_BLK_BASE_0 17'h00000
`define FMB_BLK_BASE_1 17'h00400
`define FMB_BLK_BASE_2 17'h00800
`define FMB_BLK_BASE_3 17'h00c00
`define FMB_BLK_BASE_4 17'h01000
`define FMB_BLK_BASE_5 17'h08000
`define FMB_BLK_BASE_6 17'h0c000
`define FMB_BLK_BASE_7 17'h0e000
`define FMB_BLK_BASE_8 17'h10000
`define FMB_BLK_BASE_9 17'h18000
`define FMB_RAM_ADDR_W 13
`define FMB_BOOT_AREA_BASE 13'h1f00
`define FMB_ERASE_RTN_LAST 16'h000f
`define FMB_SETTLE_LAST 2'h2
`define FMB_BAUD_SHIFT 3
`define FMB_RX_CNT_W 18
`define FMB_RX_PERIOD_W 15

`endif

// ==== fmb_pkg.sv ====
/*
  Types for the flash mode and boot controller: modes, commands, write ports
  and the state records of both modules.
  Assumes fmb_map.svh is on the include path.
*/
`include "fmb_map.svh"
package fmb_pkg;

  typedef enum logic [1:0]
  {
    FMB_USER = 2'b00,
    FMB_USER_PROG = 2'b01,
    FMB_BOOT = 2'b10,
    FMB_PROGRAMMER = 2'b11
  } fmb_mode_type;

  typedef enum logic [1:0]
  {
    FMB_OP_PROGRAM = 2'b00,
    FMB_OP_ERASE_BLOCK = 2'b01,
    FMB_OP_ERASE_ALL = 2'b10,
    FMB_OP_NONE = 2'b11
  } fmb_op_type;

  typedef enum logic [3:0]
  {
    FMB_SEQ_SETTLE = 4'h0,
    FMB_SEQ_IDLE = 4'h1,
    FMB_SEQ_PROG = 4'h2,
    FMB_SEQ_ERASE = 4'h3,
    FMB_SEQ_BAUD = 4'h4,
    FMB_SEQ_LEN_LO = 4'h5,
    FMB_SEQ_LEN_HI = 4'h6,
    FMB_SEQ_LOAD = 4'h7,
    FMB_SEQ_COPY = 4'h8
  } fmb_seq_type;

  typedef enum logic [2:0]
  {
    FMB_RX_IDLE = 3'b000,
    FMB_RX_ARM = 3'b001,
    FMB_RX_MEASURE = 3'b010,
    FMB_RX_HUNT = 3'b011,
    FMB_RX_START = 3'b100,
    FMB_RX_DATA = 3'b101,
    FMB_RX_STOP = 3'b110
  } fmb_rx_phase_type;

  typedef struct packed
  {
    fmb_op_type op;
    logic [`FMB_ADDR_W-1:0] addr;
    logic [3:0] block;
  } fmb_cmd_type;

  typedef struct packed
  {
    logic [`FMB_PAGE_IDX_W-1:0] index;
    logic [7:0] data;
  } fmb_load_type;

  typedef struct packed
  {
    logic [`FMB_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic we;
  } fmb_array_wr_type;

  typedef struct packed
  {
    logic [`FMB_RAM_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic we;
  } fmb_ram_wr_type;

  typedef struct packed
  {
    logic valid;
    logic [7:0] data;
  } fmb_byte_type;

  typedef struct packed
  {
    logic s1;
    logic s2;
    fmb_rx_phase_type phase;
    logic [`FMB_RX_CNT_W-1:0] cnt;
    logic [`FMB_RX_PERIOD_W-1:0] period;
    logic locked;
    logic [2:0] bitn;
    logic [7:0] shreg;
    fmb_byte_type out;
  } fmb_rx_state_type;

  typedef struct packed
  {
    logic [2:0] md_s1;
    logic [2:0] md_s2;
    logic pe_s1;
    logic pe_s2;
    logic [1:0] settle;
    fmb_mode_type mode;
    logic pe_status;
    fmb_seq_type seq;
    logic [`FMB_ADDR_W-1:0] addr;
    logic [`FMB_ADDR_W-1:0] last;
    logic [`FMB_PAGE_IDX_W-1:0] idx;
    logic [`FMB_PAGE_BYTES-1:0][7:0] page;
    logic [15:0] count;
    logic [15:0] length;
    logic measure;
    logic run_ctl;
    logic done;
    logic refused;
    fmb_array_wr_type arr;
    fmb_ram_wr_type ram;
  } fmb_ctrl_state_type;

endpackage

// ==== fmb_serial_rx.sv ====
/*
  Boot serial receiver with rate measurement: times the low run of the host's
  first character, then receives 8N1 bytes at the measured rate.
  Assumes the host opens with the character 80 hex, whose start bit and seven
  zero data bits give one low run of eight bit times.
*/
`timescale 1ns/1ns
`include "fmb_map.svh"
module fmb_serial_rx
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic rx_pin,
  input wire logic measure_start,
  output logic locked,
  output fmb_pkg::fmb_byte_type rx_byte
);

  fmb_pkg::fmb_rx_state_type s;
  fmb_pkg::fmb_rx_state_type next_s;

  always_comb
  begin
    next_s = s;
    next_s.s1 = rx_pin;
    next_s.s2 = s.s1;
    next_s.out.valid = 1'b0;
    next_s.cnt = s.cnt + 1'b1;
    case (s.phase)
      fmb_pkg::FMB_RX_IDLE:
      begin
        if (measure_start)
        begin
          next_s.phase = fmb_pkg::FMB_RX_ARM;
          next_s.locked = 1'b0;
        end
      end
      fmb_pkg::FMB_RX_ARM:
      begin
        next_s.cnt = '0;
        if (!s.s2)
          next_s.phase = fmb_pkg::FMB_RX_MEASURE;
      end
      fmb_pkg::FMB_RX_MEASURE:
      begin
        // Eight bit times of low, so the bit period is the run shifted down
        if (s.s2)
        begin
          next_s.period = s.cnt[`FMB_BAUD_SHIFT +: `FMB_RX_PERIOD_W];
          next_s.locked = 1'b1;
          next_s.phase = fmb_pkg::FMB_RX_HUNT;
        end
      end
      fmb_pkg::FMB_RX_HUNT:
      begin
        next_s.cnt = '0;
        if (!s.s2)
          next_s.phase = fmb_pkg::FMB_RX_START;
      end
      fmb_pkg::FMB_RX_START:
      begin
        // Recheck at mid bit so a glitch is not taken for a start bit
        if (s.cnt == {4'h0, s.period[`FMB_RX_PERIOD_W-1:1]})
        begin
          next_s.cnt = '0;
          next_s.bitn = 3'h0;
          next_s.phase = s.s2 ? fmb_pkg::FMB_RX_HUNT : fmb_pkg::FMB_RX_DATA;
        end
      end
      fmb_pkg::FMB_RX_DATA:
      begin
        if (s.cnt == {3'h0, s.period})
        begin
          next_s.cnt = '0;
          next_s.shreg = {s.s2, s.shreg[7:1]};
          next_s.bitn = s.bitn + 1'b1;
          if (s.bitn == 3'h7)
            next_s.phase = fmb_pkg::FMB_RX_STOP;
        end
      end
      fmb_pkg::FMB_RX_STOP:
      begin
        // A low stop bit is a framing fault and the byte is dropped
        if (s.cnt == {3'h0, s.period})
        begin
          next_s.out.valid = s.s2;
          next_s.out.data = s.shreg;
          next_s.phase = fmb_pkg::FMB_RX_HUNT;
        end
      end
      default:
        next_s.phase = fmb_pkg::FMB_RX_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      s <= '{s1: 1'b1, s2: 1'b1, phase: fmb_pkg::FMB_RX_IDLE, default: '0};
    else
      s <= next_s;
  end

  assign locked = s.locked;
  assign rx_byte = s.out;

endmodule

// ==== fmb_flash_ctrl.sv ====
/*
  Flash mode and boot controller: picks the operating mode at reset release,
  gates program and erase requests by mode, sequences 128-byte programming and
  block or whole-array erasure onto the array write port, and runs the boot
  flow that loads the control program into RAM over the serial line.
  Assumes an array that stores one byte per write strobe and reads on its own
  port, and a RAM with one byte write port; pins are asynchronous to clock.
*/
`timescale 1ns/1ns
`include "fmb_map.svh"
module fmb_flash_ctrl
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [2:0] mode_pins,
  input wire logic program_enable_pin_b,
  input wire logic rx_pin,
  input wire logic cmd_valid,
  input wire fmb_pkg::fmb_cmd_type cmd,
  output logic cmd_ready,
  output logic done,
  output logic refused,
  input wire logic load_valid,
  input wire fmb_pkg::fmb_load_type load,
  output logic load_ready,
  output fmb_pkg::fmb_mode_type mode,
  output logic program_enable_status,
  output logic control_program_run,
  output logic baud_locked,
  output fmb_pkg::fmb_array_wr_type array_wr,
  output fmb_pkg::fmb_ram_wr_type ram_wr
);

  fmb_pkg::fmb_ctrl_state_type s;
  fmb_pkg::fmb_ctrl_state_type next_s;
  fmb_pkg::fmb_byte_type rx_byte;
  logic rx_locked;

  fmb_serial_rx u_rx
  (
    .clock(clock),
    .rst_b(rst_b),
    .rx_pin(rx_pin),
    .measure_start(s.measure),
    .locked(rx_locked),
    .rx_byte(rx_byte)
  );

  // First address of an erase block; the next block's base bounds this one
  function automatic logic [`FMB_ADDR_W-1:0] fmb_block_base(input logic [3:0] b);
    case (b)
      4'h0: fmb_block_base = `FMB_BLK_BASE_0;
      4'h1: fmb_block_base = `FMB_BLK_BASE_1;
      4'h2: fmb_block_base = `FMB_BLK_BASE_2;
      4'h3: fmb_block_base = `FMB_BLK_BASE_3;
      4'h4: fmb_block_base = `FMB_BLK_BASE_4;
      4'h5: fmb_block_base = `FMB_BLK_BASE_5;
      4'h6: fmb_block_base = `FMB_BLK_BASE_6;
      4'h7: fmb_block_base = `FMB_BLK_BASE_7;
      4'h8: fmb_block_base = `FMB_BLK_BASE_8;
      4'h9: fmb_block_base = `FMB_BLK_BASE_9;
      default: fmb_block_base = `FMB_ARRAY_LAST;
    endcase
  endfunction

  function automatic logic [`FMB_ADDR_W-1:0] fmb_block_last(input logic [3:0] b);
    if (b == `FMB_BLOCK_LAST)
      fmb_block_last = `FMB_ARRAY_LAST;
    else
      fmb_block_last = fmb_block_base(b + 4'h1) - 1'b1;
  endfunction

  // Erase routine image copied into the boot area; the byte values are arbitrary
  function automatic logic [7:0] fmb_erase_rtn(input logic [3:0] i);
    fmb_erase_rtn = {4'ha, i} ^ 8'h5c;
  endfunction

  // Mode from the pins as they stand when the reset ends
  function automatic fmb_pkg::fmb_mode_type fmb_decode_mode(input logic [2:0] md,
                                                             input logic pe_b);
    if (pe_b)
      fmb_decode_mode = fmb_pkg::FMB_USER;
    else if (md[2:1] == 2'b00)
      fmb_decode_mode = fmb_pkg::FMB_PROGRAMMER;
    else if (!md[2])
      fmb_decode_mode = fmb_pkg::FMB_BOOT;
    else
      fmb_decode_mode = fmb_pkg::FMB_USER_PROG;
  endfunction

  logic cmd_ok;

  always_comb
  begin
    // Which requests each mode accepts
    cmd_ok = 1'b0;
    case (s.mode)
      fmb_pkg::FMB_USER:
        cmd_ok = 1'b0;
      fmb_pkg::FMB_USER_PROG:
        cmd_ok = (cmd.op == fmb_pkg::FMB_OP_PROGRAM)
                 || (cmd.op == fmb_pkg::FMB_OP_ERASE_BLOCK);
      fmb_pkg::FMB_BOOT:
        cmd_ok = (cmd.op == fmb_pkg::FMB_OP_PROGRAM)
                 || (cmd.op == fmb_pkg::FMB_OP_ERASE_ALL);
      fmb_pkg::FMB_PROGRAMMER:
        cmd_ok = (cmd.op != fmb_pkg::FMB_OP_NONE);
      default:
        cmd_ok = 1'b0;
    endcase
    if ((cmd.op == fmb_pkg::FMB_OP_PROGRAM)
        && (cmd.addr[`FMB_PAGE_IDX_W-1:0] != '0))
      cmd_ok = 1'b0;
    if ((cmd.op == fmb_pkg::FMB_OP_ERASE_BLOCK) && (cmd.block > `FMB_BLOCK_LAST))
      cmd_ok = 1'b0;
    // Losing the enable pin after reset also blocks new program and erase requests
    if (!s.pe_status)
      cmd_ok = 1'b0;
  end

  always_comb
  begin
    next_s = s;
    next_s.md_s1 = mode_pins;
    next_s.md_s2 = s.md_s1;
    next_s.pe_s1 = program_enable_pin_b;
    next_s.pe_s2 = s.pe_s1;
    next_s.pe_status = ~s.pe_s2;
    next_s.done = 1'b0;
    next_s.refused = 1'b0;
    next_s.measure = 1'b0;
    next_s.arr.we = 1'b0;
    next_s.ram.we = 1'b0;
    if (load_valid && (s.seq != fmb_pkg::FMB_SEQ_PROG))
      next_s.page[load.index] = load.data;
    case (s.seq)
      fmb_pkg::FMB_SEQ_SETTLE:
      begin
        // Wait for the pin synchronisers to fill before trusting them
        next_s.settle = s.settle + 1'b1;
        if (s.settle == `FMB_SETTLE_LAST)
        begin
          next_s.mode = fmb_decode_mode(s.md_s2, s.pe_s2);
          if (fmb_decode_mode(s.md_s2, s.pe_s2) == fmb_pkg::FMB_BOOT)
          begin
            next_s.seq = fmb_pkg::FMB_SEQ_BAUD;
            next_s.measure = 1'b1;
          end
          else
          begin
            next_s.seq = fmb_pkg::FMB_SEQ_IDLE;
          end
        end
      end
      fmb_pkg::FMB_SEQ_IDLE:
      begin
        if (cmd_valid && !cmd_ok)
        begin
          next_s.refused = 1'b1;
        end
        else if (cmd_valid && (cmd.op == fmb_pkg::FMB_OP_PROGRAM))
        begin
          next_s.addr = cmd.addr;
          next_s.idx = '0;
          next_s.seq = fmb_pkg::FMB_SEQ_PROG;
        end
        else if (cmd_valid && (cmd.op == fmb_pkg::FMB_OP_ERASE_BLOCK))
        begin
          next_s.addr = fmb_block_base(cmd.block);
          next_s.last = fmb_block_last(cmd.block);
          next_s.seq = fmb_pkg::FMB_SEQ_ERASE;
        end
        else if (cmd_valid)
        begin
          next_s.addr = '0;
          next_s.last = `FMB_ARRAY_LAST;
          next_s.seq = fmb_pkg::FMB_SEQ_ERASE;
        end
      end
      fmb_pkg::FMB_SEQ_PROG:
      begin
        // Page loads are held off here so the unit written is one snapshot
        next_s.arr.addr = s.addr | {10'h000, s.idx};
        next_s.arr.wdata = s.page[s.idx];
        next_s.arr.we = 1'b1;
        next_s.idx = s.idx + 1'b1;
        if (s.idx == `FMB_PAGE_LAST)
        begin
          next_s.seq = fmb_pkg::FMB_SEQ_IDLE;
          next_s.done = 1'b1;
        end
      end
      fmb_pkg::FMB_SEQ_ERASE:
      begin
        next_s.arr.addr = s.addr;
        next_s.arr.wdata = `FMB_ERASED_BYTE;
        next_s.arr.we = 1'b1;
        next_s.addr = s.addr + 1'b1;
        if (s.addr == s.last)
        begin
          next_s.seq = fmb_pkg::FMB_SEQ_IDLE;
          // Only the boot flow's own erase ends without a done pulse
          next_s.done = s.run_ctl || (s.mode != fmb_pkg::FMB_BOOT);
          if (s.mode == fmb_pkg::FMB_BOOT)
            next_s.run_ctl = 1'b1;
        end
      end
      fmb_pkg::FMB_SEQ_BAUD:
      begin
        if (rx_locked)
          next_s.seq = fmb_pkg::FMB_SEQ_LEN_LO;
      end
      fmb_pkg::FMB_SEQ_LEN_LO:
      begin
        if (rx_byte.valid)
        begin
          next_s.length[7:0] = rx_byte.data;
          next_s.seq = fmb_pkg::FMB_SEQ_LEN_HI;
        end
      end
      fmb_pkg::FMB_SEQ_LEN_HI:
      begin
        if (rx_byte.valid)
        begin
          next_s.length[15:8] = rx_byte.data;
          next_s.count = '0;
          next_s.seq = ({rx_byte.data, s.length[7:0]} == 16'h0000) ?
                       fmb_pkg::FMB_SEQ_COPY : fmb_pkg::FMB_SEQ_LOAD;
        end
      end
      fmb_pkg::FMB_SEQ_LOAD:
      begin
        // Lengths past the boot area base overwrite it before the copy refills it
        if (rx_byte.valid)
        begin
          next_s.ram.addr = s.count[`FMB_RAM_ADDR_W-1:0];
          next_s.ram.wdata = rx_byte.data;
          next_s.ram.we = 1'b1;
          next_s.count = s.count + 1'b1;
          if (s.count == s.length - 16'h0001)
          begin
            next_s.count = '0;
            next_s.seq = fmb_pkg::FMB_SEQ_COPY;
          end
        end
      end
      fmb_pkg::FMB_SEQ_COPY:
      begin
        next_s.ram.addr = `FMB_BOOT_AREA_BASE + s.count[`FMB_RAM_ADDR_W-1:0];
        next_s.ram.wdata = fmb_erase_rtn(s.count[3:0]);
        next_s.ram.we = 1'b1;
        next_s.count = s.count + 1'b1;
        if (s.count == `FMB_ERASE_RTN_LAST)
        begin
          next_s.addr = '0;
          next_s.last = `FMB_ARRAY_LAST;
          next_s.seq = fmb_pkg::FMB_SEQ_ERASE;
        end
      end
      default:
        next_s.seq = fmb_pkg::FMB_SEQ_SETTLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      s <= '{md_s1: 3'h0, md_s2: 3'h0, pe_s1: 1'b1, pe_s2: 1'b1,
             mode: fmb_pkg::FMB_USER, seq: fmb_pkg::FMB_SEQ_SETTLE, default: '0};
    else
      s <= next_s;
  end

  assign cmd_ready = (s.seq == fmb_pkg::FMB_SEQ_IDLE);
  assign load_ready = (s.seq != fmb_pkg::FMB_SEQ_PROG);
  assign done = s.done;
  assign refused = s.refused;
  assign mode = s.mode;
  assign program_enable_status = s.pe_status;
  assign control_program_run = s.run_ctl;
  assign baud_locked = rx_locked;
  assign array_wr = s.arr;
  assign ram_wr = s.ram;

endmodule

// ==== fmb_host_model.sv ====
/*
  Host side of the boot serial link: sends 8N1 characters, LSB first, at a
  bit period in clock cycles that the bench sets; the line idles high.
  Assumes the bench calls send just after a rising clock edge.
*/
`timescale 1ns/1ns
module fmb_host_model
(
  input wire logic clock,
  output logic tx
);
  int period = 16;
  initial tx = 1'b1;
  // The first character must be 80 hex, so that the device can time its low run
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      tx = f[i];
      repeat (period) @(posedge clock);
      #2;
    end
  endtask
endmodule

// ==== fmb_flash_ctrl_asserts.sv ====
/*
  Port checks of the flash mode and boot controller.
  Assumes the mode pins stay steady while a run lasts.
*/
`timescale 1ns/1ns
module fmb_flash_ctrl_asserts
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [2:0] mode_pins,
  input wire logic program_enable_pin_b,
  input wire logic rx_pin,
  input wire logic cmd_valid,
  input wire fmb_pkg::fmb_cmd_type cmd,
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic refused,
  input wire logic load_valid,
  input wire fmb_pkg::fmb_load_type load,
  input wire logic load_ready,
  input wire fmb_pkg::fmb_mode_type mode,
  input wire logic program_enable_status,
  input wire logic control_program_run,
  input wire logic baud_locked,
  input wire fmb_pkg::fmb_array_wr_type array_wr,
  input wire fmb_pkg::fmb_ram_wr_type ram_wr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic take;
  logic prog_ok;
  fmb_pkg::fmb_mode_type pin_mode;
  assign take = cmd_valid && cmd_ready;
  assign prog_ok = take && cmd.op == fmb_pkg::FMB_OP_PROGRAM && cmd.addr[6:0] == 7'h00
    && program_enable_status && mode inside {fmb_pkg::FMB_USER_PROG, fmb_pkg::FMB_PROGRAMMER};
  always_comb
  begin
    if (program_enable_pin_b)
      pin_mode = fmb_pkg::FMB_USER;
    else if (mode_pins[2])
      pin_mode = fmb_pkg::FMB_USER_PROG;
    else if (mode_pins[1])
      pin_mode = fmb_pkg::FMB_BOOT;
    else
      pin_mode = fmb_pkg::FMB_PROGRAMMER;
  end
  AST_MODE_PINS: assert property (cmd_ready && !program_enable_pin_b |-> mode == pin_mode)
    else $error("mode does not follow the pins");
  AST_USER_REFUSE: assert property (take && mode == fmb_pkg::FMB_USER |=> refused && !done)
    else $error("user mode request not refused");
  AST_USER_NO_WRITE: assert property (mode == fmb_pkg::FMB_USER |-> !array_wr.we)
    else $error("array written in user mode");
  AST_ALIGN: assert property (take && cmd.op == fmb_pkg::FMB_OP_PROGRAM
    && cmd.addr[6:0] != 7'h00 |=> refused)
    else $error("misaligned program unit accepted");
  AST_PROG_RUN: assert property (prog_ok |-> ##2 (array_wr.we
    && array_wr.addr == $past(cmd.addr, 2)) ##127 (done && array_wr.addr[6:0] == 7'h7f))
    else $error("program unit not 128 writes");
  AST_BOOT_FF: assert property (mode == fmb_pkg::FMB_BOOT && array_wr.we
    |-> array_wr.wdata == 8'hff)
    else $error("boot erase byte not ff");
  AST_UP_NO_ALL: assert property (take && mode == fmb_pkg::FMB_USER_PROG
    && cmd.op == fmb_pkg::FMB_OP_ERASE_ALL |=> refused)
    else $error("whole erase accepted in user program mode");
  AST_PE_STATUS: assert property ($stable(program_enable_pin_b)[*5]
    |-> program_enable_status == !program_enable_pin_b)
    else $error("enable status does not mirror pin");
  AST_RAM_BOOT: assert property (ram_wr.we |-> mode == fmb_pkg::FMB_BOOT)
    else $error("RAM written outside boot mode");
  AST_LOCK_LOAD: assert property (ram_wr.we |-> baud_locked)
    else $error("RAM load before rate lock");
endmodule
bind fmb_flash_ctrl fmb_flash_ctrl_asserts u_asserts
(
  .clock(clock), .rst_b(rst_b), .mode_pins(mode_pins),
  .program_enable_pin_b(program_enable_pin_b), .rx_pin(rx_pin), .cmd_valid(cmd_valid),
  .cmd(cmd), .cmd_ready(cmd_ready), .done(done), .refused(refused),
  .load_valid(load_valid), .load(load), .load_ready(load_ready), .mode(mode),
  .program_enable_status(program_enable_status), .control_program_run(control_program_run),
  .baud_locked(baud_locked), .array_wr(array_wr), .ram_wr(ram_wr)
);

// ==== testbench.sv ====
/*
  Bench of the flash mode and boot controller: runs every mode, queues the
  expected array and RAM writes and compares each queued write as it happens.
  Assumes the package, design, host model and checker are compiled first.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] pins = 3'b000;
  logic pe_b = 1'b1;
  logic cmd_valid = 1'b0;
  logic load_valid = 1'b0;
  logic tail_ok = 1'b0;
  logic rx, cmd_ready, done, refused, load_ready, pe_stat, run, locked;
  fmb_pkg::fmb_cmd_type cmd = '0;
  fmb_pkg::fmb_load_type load = '0;
  fmb_pkg::fmb_mode_type mode, m;
  fmb_pkg::fmb_array_wr_type aw;
  fmb_pkg::fmb_ram_wr_type rw;
  int error_cnt = 0;
  int tests_run = 0;
  logic [7:0] lfsr = 8'h80;
  logic [7:0] page[128];
  logic [24:0] aq[$];
  logic [21:0] rq[$];
  logic [21:0] re;
  logic [24:0] ae;
  logic [17:0] base[11] = '{18'h00000, 18'h00400, 18'h00800, 18'h00c00, 18'h01000,
    18'h08000, 18'h0c000, 18'h0e000, 18'h10000, 18'h18000, 18'h20000};
  fmb_host_model host
  (
    .clock(clock),
    .tx(rx)
  );
  fmb_flash_ctrl uut
  (
    .clock(clock), .rst_b(rst_b), .mode_pins(pins), .program_enable_pin_b(pe_b),
    .rx_pin(rx), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done),
    .refused(refused), .load_valid(load_valid), .load(load), .load_ready(load_ready),
    .mode(mode), .program_enable_status(pe_stat), .control_program_run(run),
    .baud_locked(locked), .array_wr(aw), .ram_wr(rw)
  );
  initial
  begin
    forever #20 clock = ~clock;
  end
  // Sampled mid-cycle so that registered outputs have settled
  always @(negedge clock)
  begin
    // Popped once into a temporary, since the macro names its expected value twice
    if (aw.we === 1'b1 && aq.size() != 0)
    begin
      ae = aq.pop_front();
      `CHK({aw.addr, aw.wdata}, ae)
    end
    else if (aw.we !== 1'b0 && !tail_ok)
      `CHK(aw.we, 1'b0)
    if (rw.we === 1'b1)
    begin
      re = rq.pop_front();
      `CHK({rw.addr, rw.wdata & {8{re[21]}}}, re[20:0])
    end
  end
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    $display("[FAIL] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    results();
  endtask
  task automatic start(input logic [2:0] p, input logic b);
    rst_b = 1'b0;
    tail_ok = 1'b0;
    pins = p;
    pe_b = b;
    aq.delete();
    rq.delete();
    cyc(8);
    rst_b = 1'b1;
    cyc(5);
    m = b ? fmb_pkg::FMB_USER : p[2] ? fmb_pkg::FMB_USER_PROG :
      p[1] ? fmb_pkg::FMB_BOOT : fmb_pkg::FMB_PROGRAMMER;
    `CHK(mode, m)
    `CHK(pe_stat, ~b)
  endtask
  task automatic fill();
    for (int i = 0; i < 128; i++)
    begin
      lfsr = nxt(lfsr);
      page[i] = lfsr;
      load_valid = 1'b1;
      load = '{i[6:0], lfsr};
      cyc();
    end
    load_valid = 1'b0;
  endtask
  // The bench model decides refusal and queues the writes an accepted program or block erase makes
  task automatic issue(input fmb_pkg::fmb_op_type op, input logic [16:0] a, input logic [3:0] k);
    logic rej;
    int n;
    rej = m == fmb_pkg::FMB_USER || pe_b
      || (op == fmb_pkg::FMB_OP_PROGRAM && a[6:0] != 7'h00)
      || (op == fmb_pkg::FMB_OP_ERASE_BLOCK && k > 4'h9)
      || (op == fmb_pkg::FMB_OP_ERASE_ALL && m == fmb_pkg::FMB_USER_PROG);
    if (!rej && op == fmb_pkg::FMB_OP_PROGRAM)
      for (int i = 0; i < 128; i++) aq.push_back({a + 17'(i), page[i]});
    if (!rej && op == fmb_pkg::FMB_OP_ERASE_BLOCK)
      for (int i = base[k]; i < base[k + 1]; i++) aq.push_back({i[16:0], 8'hff});
    n = 0;
    while (cmd_ready !== 1'b1)
    begin
      if (++n > 50) tmo();
      cyc();
    end
    cmd_valid = 1'b1;
    cmd = '{op, a, k};
    cyc();
    cmd_valid = 1'b0;
    `CHK(cmd_ready, rej)
    `CHK(load_ready, rej || op != fmb_pkg::FMB_OP_PROGRAM)
    n = 0;
    while (done !== 1'b1 && refused !== 1'b1)
    begin
      if (++n > 40000) tmo();
      cyc();
    end
    `CHK(done, ~rej)
    `CHK(refused, rej)
    cyc();
    `CHK(aq.size(), 0)
  endtask
  task automatic boot_run(input int per, input int len);
    logic [7:0] img[8];
    int n;
    start(3'b010, 1'b0);
    host.period = per;
    tail_ok = 1'b1;
    for (int i = 0; i < len; i++)
    begin
      lfsr = nxt(lfsr);
      img[i] = lfsr;
      rq.push_back({1'b1, 13'(i), lfsr});
    end
    // The erase routine content is the designer's own, so only its addresses are compared
    for (int i = 0; i < 16; i++) rq.push_back({1'b0, 13'h1f00 + 13'(i), 8'h00});
    for (int i = 0; i < 256; i++) aq.push_back({17'(i), 8'hff});
    cyc(4);
    host.send(8'h80);
    host.send(8'(len));
    host.send(8'h00);
    for (int i = 0; i < len; i++) host.send(img[i]);
    `CHK(locked, 1'b1)
    n = 0;
    while (aq.size() != 0)
    begin
      if (++n > 5000) tmo();
      cyc();
    end
    `CHK(rq.size(), 0)
    `CHK(run, 1'b0)
    $display("boot run with period %0d done", per);
  endtask
  initial
  begin
    start(3'b100, 1'b1);
    for (int i = 0; i < 3; i++) issue(fmb_pkg::fmb_op_type'(i), 17'h00000, 4'h0);
    $display("user mode test done");
    start(3'b100, 1'b0);
    fill();
    issue(fmb_pkg::FMB_OP_PROGRAM, 17'h00180, 4'h0);
    fill();
    issue(fmb_pkg::FMB_OP_PROGRAM, 17'h1ff80, 4'h0);
    issue(fmb_pkg::FMB_OP_PROGRAM, 17'h00140, 4'h0);
    issue(fmb_pkg::FMB_OP_ERASE_ALL, 17'h00000, 4'h0);
    issue(fmb_pkg::FMB_OP_ERASE_BLOCK, 17'h00000, 4'ha);
    issue(fmb_pkg::FMB_OP_ERASE_BLOCK, 17'h00000, 4'h0);
    issue(fmb_pkg::FMB_OP_ERASE_BLOCK, 17'h00000, 4'h1);
    pe_b = 1'b1;
    cyc(5);
    `CHK(pe_stat, 1'b0)
    issue(fmb_pkg::FMB_OP_PROGRAM, 17'h00000, 4'h0);
    pe_b = 1'b0;
    cyc(5);
    $display("user program mode test done");
    start(3'b000, 1'b0);
    fill();
    issue(fmb_pkg::FMB_OP_ERASE_BLOCK, 17'h00000, 4'h3);
    issue(fmb_pkg::FMB_OP_PROGRAM, 17'h00c00, 4'h0);
    $display("programmer mode test done");
    boot_run(16, 3);
    boot_run(40, 0);
    results();
  end
endmodule
